// ### lcdpi_pkg.sv
/*
 * Package for the common-electrode polarity inversion block: register map, field
 * positions, reset values, bus response codes, carrier structs and state types.
 * Assumes a 32-bit AXI4-Lite register bus and a three-bit serial mode header.
 */
package lcdpi_pkg;

	// -----------------------------------------------------------------
	// Register map
	// -----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] COUNT_OFFSET = 8'h08;

	localparam int CTRL_COUNT_EN_BIT = 0;
	localparam logic [31:0] CTRL_RESET = 32'h00000001;

	localparam int STATUS_COMMON_BIT = 0;
	localparam int STATUS_ARMED_BIT = 1;
	localparam int STATUS_HW_MODE_BIT = 2;
	localparam int STATUS_FLAG_BIT = 3;

	localparam int COUNT_W = 16;
	localparam logic [15:0] COUNT_RESET = 16'h0000;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// -----------------------------------------------------------------
	// Serial mode header
	// -----------------------------------------------------------------
	localparam int MODE_BITS = 3;
	localparam logic [1:0] MODE_LAST_INDEX = 2'h2;
	localparam int MODE_POLARITY_BIT = 1;

	typedef enum logic [1:0] {
		CAP_IDLE,
		CAP_MODE,
		CAP_DONE
	} lcdpi_cap_phase_t;

	typedef struct packed {
		logic valid;
		logic [MODE_BITS-1:0] bits;
	} lcdpi_mode_flags_t;

	typedef struct packed {
		lcdpi_cap_phase_t phase;
		logic sclk_prev;
		logic [1:0] bit_cnt;
		logic [MODE_BITS-1:0] shift;
		lcdpi_mode_flags_t flags;
	} lcdpi_cap_state_t;

	typedef struct packed {
		logic hw_mode;
		logic ext_prev;
		logic armed;
		logic common;
		logic polarity_flag;
		logic count_en;
		logic [COUNT_W-1:0] toggles;
		logic awready;
		logic wready;
		logic aw_done;
		logic w_done;
		logic [ADDR_W-1:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} lcdpi_state_t;

endpackage

// ### lcdpi_mode_capture.sv
/*
 * Serial mode header capture. Collects the first three serial bits after the
 * panel select rises and presents them, with a one-cycle valid pulse.
 * Assumes serial clock, data and select are synchronous to the system clock and
 * that the serial clock is far slower than it.
 */
`timescale 1ns/100ps
module lcdpi_mode_capture (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic panel_select_i,
	input wire logic serial_clock_i,
	input wire logic serial_data_i,
	output lcdpi_pkg::lcdpi_mode_flags_t flags_o
);

	lcdpi_pkg::lcdpi_cap_state_t st;
	lcdpi_pkg::lcdpi_cap_state_t next_st;
	logic sclk_rise;

	// -----------------------------------------------------------------
	// Header shift
	// -----------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.sclk_prev = serial_clock_i;
		next_st.flags.valid = 1'b0;
		sclk_rise = serial_clock_i && !st.sclk_prev;
		case (st.phase)
			lcdpi_pkg::CAP_IDLE: begin
				next_st.bit_cnt = 2'h0;
				if (panel_select_i) begin
					next_st.phase = lcdpi_pkg::CAP_MODE;
				end
			end
			lcdpi_pkg::CAP_MODE: begin
				if (!panel_select_i) begin
					// An aborted header leaves the last complete flags in place.
					next_st.phase = lcdpi_pkg::CAP_IDLE;
				end else if (sclk_rise) begin
					next_st.shift = {serial_data_i, st.shift[lcdpi_pkg::MODE_BITS-1:1]};
					next_st.bit_cnt = st.bit_cnt + 2'h1;
					if (st.bit_cnt == lcdpi_pkg::MODE_LAST_INDEX) begin
						next_st.flags.valid = 1'b1;
						next_st.flags.bits = {serial_data_i, st.shift[lcdpi_pkg::MODE_BITS-1:1]};
						next_st.phase = lcdpi_pkg::CAP_DONE;
					end
				end
			end
			lcdpi_pkg::CAP_DONE: begin
				if (!panel_select_i) begin
					next_st.phase = lcdpi_pkg::CAP_IDLE;
				end
			end
			default: begin
				next_st.phase = lcdpi_pkg::CAP_IDLE;
			end
		endcase
		if (reset_i) begin
			next_st = '0;
			next_st.phase = lcdpi_pkg::CAP_IDLE;
			next_st.sclk_prev = serial_clock_i;
		end
	end

	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	assign flags_o = st.flags;

endmodule

// ### lcdpi_inversion.sv
/*
 * Common-electrode polarity inversion for a reflective memory panel, with an
 * AXI4-Lite register slave for control and status.
 * Assumes all pins are synchronous to SYS_CLK_I and that the inversion source
 * strap is stable from reset onward.
 */
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
module lcdpi_inversion (
	input wire logic SYS_CLK_I,
	input wire logic RESET_I,
	input wire logic PANEL_SELECT_I,
	input wire logic SERIAL_CLOCK_I,
	input wire logic SERIAL_DATA_I,
	input wire logic EXTERNAL_INVERSION_CLOCK_I,
	input wire logic INVERSION_SOURCE_SELECT_I,
	output logic COMMON_ELECTRODE_POLARITY_O,
	output logic ARMED_POLARITY_O,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [7:0] S_AXI_AWADDR_I,
	input wire logic [2:0] S_AXI_AWPROT_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	output logic [1:0] S_AXI_BRESP_O,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	input wire logic [7:0] S_AXI_ARADDR_I,
	input wire logic [2:0] S_AXI_ARPROT_I,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O
);

	lcdpi_pkg::lcdpi_state_t st;
	lcdpi_pkg::lcdpi_state_t next_st;
	lcdpi_pkg::lcdpi_mode_flags_t cap_flags;
	logic ext_rise;
	logic aw_take;
	logic w_take;
	logic ar_take;

	// -----------------------------------------------------------------
	// Address decode
	// -----------------------------------------------------------------
	function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] offset);
		addr_is = (addr[7:2] == offset[7:2]);
	endfunction

	function automatic logic addr_known(input logic [7:0] addr);
		addr_known = addr_is(addr, lcdpi_pkg::CTRL_OFFSET) ||
			addr_is(addr, lcdpi_pkg::STATUS_OFFSET) ||
			addr_is(addr, lcdpi_pkg::COUNT_OFFSET);
	endfunction

	// -----------------------------------------------------------------
	// Serial header capture
	// -----------------------------------------------------------------
	lcdpi_mode_capture u_capture (
		.clk_i(SYS_CLK_I),
		.reset_i(RESET_I),
		.panel_select_i(PANEL_SELECT_I),
		.serial_clock_i(SERIAL_CLOCK_I),
		.serial_data_i(SERIAL_DATA_I),
		.flags_o(cap_flags)
	);

	// -----------------------------------------------------------------
	// Next state
	// -----------------------------------------------------------------
	always_comb begin
		next_st = st;
		ext_rise = EXTERNAL_INVERSION_CLOCK_I && !st.ext_prev;
		aw_take = S_AXI_AWVALID_I && st.awready;
		w_take = S_AXI_WVALID_I && st.wready;
		ar_take = S_AXI_ARVALID_I && st.arready;
		next_st.ext_prev = EXTERNAL_INVERSION_CLOCK_I;

		if (cap_flags.valid) begin
			next_st.polarity_flag = cap_flags.bits[lcdpi_pkg::MODE_POLARITY_BIT];
		end

		if (st.hw_mode) begin
			// The header flag is never consulted here.
			if (ext_rise) begin
				next_st.armed = !st.armed;
			end
			// Holding while select is high defers any change to the select fall; while low it tracks armed.
			if (!PANEL_SELECT_I) begin
				next_st.common = st.armed;
			end
		end else if (cap_flags.valid) begin
			// The inversion clock is not looked at in this mode.
			next_st.common = cap_flags.bits[lcdpi_pkg::MODE_POLARITY_BIT];
		end

		if (st.count_en && (next_st.common != st.common)) begin
			next_st.toggles = st.toggles + 16'h0001;
		end

		// Write channel: address and data are taken in either order.
		if (aw_take) begin
			next_st.aw_done = 1'b1;
			next_st.aw_addr = S_AXI_AWADDR_I;
		end
		if (w_take) begin
			next_st.w_done = 1'b1;
			next_st.w_data = S_AXI_WDATA_I;
			next_st.w_strb = S_AXI_WSTRB_I;
		end
		if (st.bvalid && S_AXI_BREADY_I) begin
			next_st.bvalid = 1'b0;
		end
		if (st.aw_done && st.w_done && !st.bvalid) begin
			next_st.aw_done = 1'b0;
			next_st.w_done = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = lcdpi_pkg::RESP_SLVERR;
			if (addr_known(st.aw_addr)) begin
				next_st.bresp = lcdpi_pkg::RESP_OKAY;
			end
			if (addr_is(st.aw_addr, lcdpi_pkg::CTRL_OFFSET) && st.w_strb[0]) begin
				next_st.count_en = st.w_data[lcdpi_pkg::CTRL_COUNT_EN_BIT];
			end
		end
		next_st.awready = !next_st.aw_done && !next_st.bvalid;
		next_st.wready = !next_st.w_done && !next_st.bvalid;

		// Read channel: one read in flight, answered the cycle after it is taken.
		if (st.rvalid && S_AXI_RREADY_I) begin
			next_st.rvalid = 1'b0;
		end
		if (ar_take) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = 32'h00000000;
			next_st.rresp = lcdpi_pkg::RESP_OKAY;
			if (addr_is(S_AXI_ARADDR_I, lcdpi_pkg::CTRL_OFFSET)) begin
				next_st.rdata[lcdpi_pkg::CTRL_COUNT_EN_BIT] = st.count_en;
			end else if (addr_is(S_AXI_ARADDR_I, lcdpi_pkg::STATUS_OFFSET)) begin
				next_st.rdata[lcdpi_pkg::STATUS_COMMON_BIT] = st.common;
				next_st.rdata[lcdpi_pkg::STATUS_ARMED_BIT] = st.armed;
				next_st.rdata[lcdpi_pkg::STATUS_HW_MODE_BIT] = st.hw_mode;
				next_st.rdata[lcdpi_pkg::STATUS_FLAG_BIT] = st.polarity_flag;
			end else if (addr_is(S_AXI_ARADDR_I, lcdpi_pkg::COUNT_OFFSET)) begin
				next_st.rdata = {16'h0000, st.toggles};
			end else begin
				next_st.rresp = lcdpi_pkg::RESP_SLVERR;
			end
		end
		next_st.arready = !next_st.rvalid;

		if (RESET_I) begin
			next_st = '0;
			// The strap is sampled during reset and held until the next one.
			next_st.hw_mode = INVERSION_SOURCE_SELECT_I;
			// Seeding the edge detector avoids a false rise at reset release.
			next_st.ext_prev = EXTERNAL_INVERSION_CLOCK_I;
			next_st.count_en = lcdpi_pkg::CTRL_RESET[lcdpi_pkg::CTRL_COUNT_EN_BIT];
			next_st.toggles = lcdpi_pkg::COUNT_RESET;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		st <= next_st;
	end

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	assign COMMON_ELECTRODE_POLARITY_O = st.common;
	assign ARMED_POLARITY_O = st.armed;
	assign S_AXI_AWREADY_O = st.awready;
	assign S_AXI_WREADY_O = st.wready;
	assign S_AXI_BVALID_O = st.bvalid;
	assign S_AXI_BRESP_O = st.bresp;
	assign S_AXI_ARREADY_O = st.arready;
	assign S_AXI_RVALID_O = st.rvalid;
	assign S_AXI_RDATA_O = st.rdata;
	assign S_AXI_RRESP_O = st.rresp;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (RESET_I);

	chk_sw_flag_follow: assert property (
		(!st.hw_mode && cap_flags.valid) |=>
			(st.common == $past(cap_flags.bits[lcdpi_pkg::MODE_POLARITY_BIT])))
		else $error("software mode electrode did not follow the flag");

	chk_sw_clock_ignored: assert property (
		(!st.hw_mode && !cap_flags.valid && ext_rise) |=> $stable(st.common) && $stable(st.armed))
		else $error("inversion clock disturbed software mode polarity");

	chk_hw_flag_ignored: assert property (
		(st.hw_mode && cap_flags.valid) |=>
			(st.common == ($past(PANEL_SELECT_I) ? $past(st.common) : $past(st.armed))))
		else $error("hardware mode polarity moved on a header flag");

	chk_arm_toggle: assert property (
		(st.hw_mode && EXTERNAL_INVERSION_CLOCK_I && !st.ext_prev) |=> (st.armed != $past(st.armed)))
		else $error("armed polarity missed an inversion clock rise");

	chk_arm_hold: assert property (
		(st.hw_mode && !(EXTERNAL_INVERSION_CLOCK_I && !st.ext_prev)) |=> $stable(st.armed))
		else $error("armed polarity changed without a clock rise");

	chk_common_follow: assert property (
		(st.hw_mode && !PANEL_SELECT_I) |=> (st.common == $past(st.armed)))
		else $error("electrode did not take the armed polarity while deselected");

	chk_common_hold: assert property (
		(st.hw_mode && PANEL_SELECT_I) |=> $stable(st.common))
		else $error("electrode changed while the panel was selected");

	chk_bresp_hold: assert property (
		(st.bvalid && !S_AXI_BREADY_I) |=> (st.bvalid && $stable(st.bresp)))
		else $error("write response dropped before it was taken");

	chk_read_answer: assert property (
		(S_AXI_ARVALID_I && st.arready) |=> st.rvalid ##0 !st.arready)
		else $error("read not answered the cycle after it was taken");

	chk_write_answer: assert property (
		(st.aw_done && st.w_done && !st.bvalid) |=> st.bvalid)
		else $error("write not answered after address and data were taken");

	chk_aw_refused: assert property (
		(st.aw_done || st.bvalid) |-> !st.awready)
		else $error("write address accepted while a write was pending");

	chk_w_refused: assert property (
		(st.w_done || st.bvalid) |-> !st.wready)
		else $error("write data accepted while a write was pending");

	chk_ar_refused: assert property (
		st.rvalid |-> !st.arready)
		else $error("read address accepted while read data was pending");

	chk_rdata_hold: assert property (
		(st.rvalid && !S_AXI_RREADY_I) |=> (st.rvalid && $stable(st.rdata) && $stable(st.rresp)))
		else $error("read data changed before it was taken");

	// -----------------------------------------------------------------
	// Polarity source checks
	// -----------------------------------------------------------------
	// A software-mode panel never arms anything; a stray armed bit would
	// leak into the electrode as soon as the strap read differently.
	chk_sw_arm_idle: assert property (
		!st.hw_mode |-> !st.armed)
		else $error("armed polarity moved in software mode");

	chk_sw_common_hold: assert property (
		(!st.hw_mode && !cap_flags.valid) |=> $stable(st.common))
		else $error("software mode electrode moved without a header");

	chk_strap_held: assert property (
		$stable(st.hw_mode))
		else $error("inversion source changed outside reset");

	chk_cap_pulse: assert property (
		cap_flags.valid |=> !cap_flags.valid)
		else $error("header valid pulse lasted more than one cycle");

	// -----------------------------------------------------------------
	// Counter checks
	// -----------------------------------------------------------------
	// The counter wraps silently: software must read it as a modular delta.
	chk_count_step: assert property (
		st.count_en |=>
			(st.toggles == $past(st.toggles) + {15'h0000, $changed(st.common)}))
		else $error("toggle count did not follow the electrode");

	chk_count_hold: assert property (
		!st.count_en |=> $stable(st.toggles))
		else $error("toggle count moved while counting was off");

	cov_sw_update: cover property (!st.hw_mode && cap_flags.valid ##1 $changed(st.common));
	cov_hw_arm: cover property (st.hw_mode && PANEL_SELECT_I && ext_rise ##1 !PANEL_SELECT_I
		##1 $changed(st.common));
	cov_write_ctrl: cover property (st.bvalid && S_AXI_BREADY_I && st.bresp == lcdpi_pkg::RESP_OKAY);
	cov_read_count: cover property (st.rvalid && S_AXI_RREADY_I && st.rdata != 32'h00000000);

endmodule

// ### lcdpi_host_model.sv
/*
 * Host controller model for the polarity inversion block: panel select, serial
 * mode header and external inversion clock.
 * Assumes the caller enters each task just after a rising edge of clk_i.
 */
`timescale 1ns/100ps
module lcdpi_host_model (
	input wire logic clk_i,
	output logic panel_select_o,
	output logic serial_clock_o,
	output logic serial_data_o,
	output logic inversion_clock_o
);
	initial begin
		panel_select_o = 1'h0;
		serial_clock_o = 1'h0;
		serial_data_o = 1'h0;
		inversion_clock_o = 1'h0;
	end

	// Mode bit, polarity flag and clear-all bit go out first bit first.
	// Each header stands for a full rewrite, repeated far inside two hours.
	task automatic header(input logic flag);
		logic [2:0] hdr;
		hdr = {1'h0, flag, 1'h0};
		panel_select_o <= 1'h1;
		for (int i = 2; i >= 0; i--) begin
			@(posedge clk_i) serial_data_o <= hdr[i];
			@(posedge clk_i) serial_clock_o <= 1'h1;
			@(posedge clk_i) serial_clock_o <= 1'h0;
		end
		// A released data line must not keep looking like the last bit.
		@(posedge clk_i) serial_data_o <= ~serial_data_o;
		repeat (3) @(posedge clk_i);
		panel_select_o <= 1'h0;
		@(posedge clk_i);
	endtask

	task automatic sel(input logic v);
		panel_select_o <= v;
		@(posedge clk_i);
	endtask

	// Equal phases keep both polarities equally long; periods stay far below a second.
	task automatic invert(input int half);
		inversion_clock_o <= 1'h1;
		repeat (half) @(posedge clk_i);
		inversion_clock_o <= 1'h0;
		repeat (half) @(posedge clk_i);
	endtask
endmodule

// ### test_lcdpi_inversion.sv
/*
 * Self-checking testbench for the polarity inversion block.
 * Assumes the host model drives the panel pins and the bench drives the register bus.
 */
`timescale 1ns/100ps
module test_lcdpi_inversion;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic strap = 1'h0;
	logic sel, sclk, sdata, inv, common, armed;
	logic awvalid = 1'h0, awready, wvalid = 1'h0, wready, bvalid, bready = 1'h0;
	logic arvalid = 1'h0, arready, rvalid, rready = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000, rdata, d;
	logic [1:0] bresp, rresp, r;
	logic [3:0] wstrb = 4'hF;
	logic [2:0] prot = 3'h0;
	int err_count = 0;
	int n_tests = 0;

	initial forever #50 clk = ~clk;

	lcdpi_host_model host (.clk_i(clk), .panel_select_o(sel), .serial_clock_o(sclk),
		.serial_data_o(sdata), .inversion_clock_o(inv));

	lcdpi_inversion dut (.SYS_CLK_I(clk), .RESET_I(rst), .PANEL_SELECT_I(sel),
		.SERIAL_CLOCK_I(sclk), .SERIAL_DATA_I(sdata), .EXTERNAL_INVERSION_CLOCK_I(inv),
		.INVERSION_SOURCE_SELECT_I(strap), .COMMON_ELECTRODE_POLARITY_O(common),
		.ARMED_POLARITY_O(armed), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
		.S_AXI_AWADDR_I(awaddr), .S_AXI_AWPROT_I(prot), .S_AXI_WVALID_I(wvalid),
		.S_AXI_WREADY_O(wready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb),
		.S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_BRESP_O(bresp),
		.S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_ARADDR_I(araddr),
		.S_AXI_ARPROT_I(prot), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
		.S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp));

	// ---------------------------------------------------------------
	// Checking and bus tasks
	// ---------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic pins(input logic c, input logic a);
		@(negedge clk);
		chk("common", {31'h0, common}, {31'h0, c});
		chk("armed", {31'h0, armed}, {31'h0, a});
		@(posedge clk);
	endtask

	// Handshakes are judged at the falling edge, where registered readies have settled.
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		logic pa, pw, pb, ha, hw, hb;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		pa = 1'h1;
		pw = 1'h1;
		pb = 1'h1;
		while (pa || pw || pb) begin
			@(negedge clk);
			ha = pa && awready;
			hw = pw && wready;
			hb = pb && bvalid;
			if (hb) r = bresp;
			@(posedge clk);
			if (ha) awvalid <= 1'h0;
			if (hw) wvalid <= 1'h0;
			if (hb) bready <= 1'h0;
			pa = pa && !ha;
			pw = pw && !hw;
			pb = pb && !hb;
		end
		@(posedge clk);
	endtask

	task automatic axr(input logic [7:0] a);
		logic pa, pr, ha, hr;
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		pa = 1'h1;
		pr = 1'h1;
		while (pa || pr) begin
			@(negedge clk);
			ha = pa && arready;
			hr = pr && rvalid;
			if (hr) d = rdata;
			if (hr) r = rresp;
			@(posedge clk);
			if (ha) arvalid <= 1'h0;
			if (hr) rready <= 1'h0;
			pa = pa && !ha;
			pr = pr && !hr;
		end
		@(posedge clk);
	endtask

	// The strap only changes while reset is held.
	task automatic reset_dut(input logic s);
		strap <= s;
		rst <= 1'h1;
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
	endtask

	task automatic close_out;
		$display("Checks %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	initial begin
		reset_dut(1'h0);
		pins(1'h0, 1'h0);
		axr(lcdpi_pkg::CTRL_OFFSET);
		chk("ctrl", d, lcdpi_pkg::CTRL_RESET);
		axr(8'h0C);
		chk("rresp", {30'h0, r}, {30'h0, lcdpi_pkg::RESP_SLVERR});
		chk("rdata", d, 32'h00000000);
		host.header(1'h1);
		pins(1'h1, 1'h0);
		host.invert(4);
		pins(1'h1, 1'h0);
		axr(lcdpi_pkg::STATUS_OFFSET);
		chk("status", d, 32'h00000009);
		host.header(1'h0);
		pins(1'h0, 1'h0);
		axr(lcdpi_pkg::COUNT_OFFSET);
		chk("count", d, 32'h00000002);
		axw(lcdpi_pkg::CTRL_OFFSET, 32'h00000000);
		chk("bresp", {30'h0, r}, {30'h0, lcdpi_pkg::RESP_OKAY});
		host.header(1'h1);
		pins(1'h1, 1'h0);
		axr(lcdpi_pkg::COUNT_OFFSET);
		chk("count held", d, 32'h00000002);
		// A write without strobe bit 0 must leave the enable alone; protection is ignored.
		wstrb <= 4'hE;
		prot <= 3'h7;
		axw(lcdpi_pkg::CTRL_OFFSET, 32'h00000001);
		chk("bresp", {30'h0, r}, {30'h0, lcdpi_pkg::RESP_OKAY});
		axr(lcdpi_pkg::CTRL_OFFSET);
		chk("ctrl strobe", d, 32'h00000000);
		wstrb <= 4'hF;
		axw(lcdpi_pkg::CTRL_OFFSET, 32'h00000001);
		axr(lcdpi_pkg::CTRL_OFFSET);
		chk("ctrl", d, 32'h00000001);
		axw(8'h0C, 32'hFFFFFFFF);
		chk("bresp", {30'h0, r}, {30'h0, lcdpi_pkg::RESP_SLVERR});
		// Second reset in mid-run switches to hardware inversion.
		reset_dut(1'h1);
		pins(1'h0, 1'h0);
		axr(lcdpi_pkg::STATUS_OFFSET);
		chk("status", d, 32'h00000004);
		host.header(1'h1);
		pins(1'h0, 1'h0);
		host.invert(4);
		pins(1'h1, 1'h1);
		host.sel(1'h1);
		host.invert(4);
		pins(1'h1, 1'h0);
		host.sel(1'h0);
		repeat (2) @(posedge clk);
		pins(1'h0, 1'h0);
		axr(lcdpi_pkg::COUNT_OFFSET);
		chk("count", d, 32'h00000002);
		close_out;
	end

	initial begin
		repeat (3000) @(posedge clk);
		err_count++;
		close_out;
	end
endmodule
